// ==== pkg/som_consts.vh ====
// Constants for the status output monitor: register map, fields, resets.
// Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
`ifndef SOM_CONSTS_VH
`define SOM_CONSTS_VH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define SOM_OFF_CTRL 8'h00
`define SOM_OFF_START_FREQ 8'h04
`define SOM_OFF_PV_HIGH 8'h08
`define SOM_OFF_PV_LOW 8'h0c
`define SOM_OFF_SETPOINT 8'h10
`define SOM_OFF_STATUS 8'h14
`define SOM_OFF_IRQ_STAT 8'h18
`define SOM_OFF_IRQ_MASK 8'h1c
`define SOM_OFF_VOLT_MON 8'h20
`define SOM_OFF_CURR_MON 8'h24

// -----------------------------------------------------------------
// Control fields
// -----------------------------------------------------------------
`define SOM_CTRL_SRC_BIT 0
`define SOM_CTRL_DECEL_BIT 1
`define SOM_CTRL_LOSS_SEL_BIT 2
`define SOM_CTRL_STAGE_SEL_BIT 3

// -----------------------------------------------------------------
// Interrupt event bits
// -----------------------------------------------------------------
`define SOM_EV_LOSS_SET 0
`define SOM_EV_LOSS_CLR 1
`define SOM_EV_STAGE_SET 2
`define SOM_EV_STAGE_CLR 3

// -----------------------------------------------------------------
// Reset values and scaling
// -----------------------------------------------------------------
`define SOM_CTRL_RST 4'hf
`define SOM_START_FREQ_RST 16'h0000
`define SOM_PV_HIGH_RST 16'h0000
`define SOM_PV_LOW_RST 16'h0000
`define SOM_SETPOINT_RST 16'h0000
// Current input scale: code = microamps, 4 mA floor, 20 mA full scale
`define SOM_CURR_FLOOR_UA 16'h0fa0
`define SOM_CURR_FULL_UA 16'h4e20

`endif

// ==== hdl/som_hyst_flag.v ====
// Hysteresis flag for the second-stage helper drive.
// Assumes the process value and limits share one percent scale.
`timescale 1ns/100ps

module som_hyst_flag
#(
    parameter W = 16
)
(
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Comparison inputs
    input wire run,
    input wire sample,
    input wire [W-1:0] value,
    input wire [W-1:0] low_lim,
    input wire [W-1:0] high_lim,
    // Flag
    output reg flag_q
);

    // -----------------------------------------------------------------
    // Two-threshold flag
    // -----------------------------------------------------------------
    // Between the limits the flag holds, giving the hysteresis band
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flag_q <= 1'b0; // see (R15)
        else if (!run)
            flag_q <= 1'b0; // see (R12)
        else if (sample)
        begin
            if (value < low_lim)
                flag_q <= 1'b1; // see (R8) see (R11)
            else if (value > high_lim)
                flag_q <= 1'b0; // see (R9)
            // see (R10)
        end
    end

endmodule

// ==== hdl/som_top.v ====
// Status output monitor: reference-loss flag and second-stage flag.
// Assumes Avalon-MM master on CLK_IN; measurements synchronous to it.
//
// Overview of operation
// (R1) Loss flag set when voltage reference is below start frequency threshold.
// (R2) Loss flag also set when current reference is below 4 mA.
// (R3) Current reference spans 4 to 20 mA, 4 mA is range bottom.
// (R4) Reference loss is no trip; nothing latches, nothing to clear.
// (R5) Loss flag falls by itself once input is above threshold.
// (R6) On reference loss the drive decelerates to stop by default.
// (R7) Loss flag is selectable onto an intelligent output terminal.
// (R8) Run start with value below low limit sets stage flag at once.
// (R9) While running, value above high limit clears stage flag.
// (R10) Between limits after a high crossing, stage flag stays clear.
// (R11) While running, value below low limit sets stage flag again.
// (R12) Leaving run mode clears stage flag whatever the value.
// (R13) Setpoint and both limits use one percent scale.
// (R14) Helper drive runs forward while stage flag is set.
// (R15) Comparisons run on each sample strobe; flags clear on reset.
`timescale 1ns/100ps
`include "som_consts.vh"

module som_top
#(
    parameter W = 16
)
(
    // Clock and reset
    input wire CLK_IN,
    input wire RST_N_IN,
    // Avalon-MM slave
    input wire [7:0] AVS_ADDRESS_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire [31:0] AVS_WRITEDATA_IN,
    input wire [3:0] AVS_BYTEENABLE_IN,
    output reg [31:0] AVS_READDATA_OUT,
    output reg AVS_WAITREQUEST_OUT,
    // Drive measurements and run state
    input wire SAMPLE_IN,
    input wire FORWARD_RUN_CMD_IN,
    input wire [W-1:0] VOLT_REF_IN,
    input wire [W-1:0] CURRENT_REF_INPUT_IN,
    input wire [W-1:0] PROCESS_VALUE_IN,
    // Status outputs
    output reg INPUT_LOSS_FLAG_OUT,
    output reg SECOND_STAGE_FLAG_OUT,
    output reg TERMINAL_LOSS_OUT,
    output reg TERMINAL_STAGE_OUT,
    output reg DECEL_STOP_REQ_OUT,
    output reg IRQ_OUT
);

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    reg [3:0] ctrl_q;
    reg [W-1:0] start_freq_threshold_q;
    reg [W-1:0] pv_high_limit_q;
    reg [W-1:0] pv_low_limit_q;
    reg [W-1:0] setpoint_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    reg [3:0] irq_stat_d;
    reg input_loss_flag_q;
    reg loss_d;
    reg volt_loss;
    reg curr_loss;
    reg [W-1:0] curr_pct;
    reg ack_q;
    reg [31:0] rdata_d;
    reg [31:0] wr_word;
    reg prev_loss_q;
    reg prev_stage_q;
    wire second_stage_flag;
    wire bus_req;
    wire wr_go;
    wire rd_go;
    wire [3:0] events;

    // Merge a field write under byte enables
    function [31:0] merge;
        input [31:0] old;
        input [31:0] wdata;
        input [3:0] be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (be[i])
                    merge[i*8 +: 8] = wdata[i*8 +: 8];
        end
    endfunction

    // Zero-extend a W-bit field into a bus word
    function [31:0] widen;
        input [W-1:0] v;
        begin
            widen = 32'h0000_0000;
            widen[W-1:0] = v;
        end
    endfunction

    // -----------------------------------------------------------------
    // Avalon-MM handshake
    // -----------------------------------------------------------------
    // One wait cycle per access: waitrequest falls in the second cycle
    assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
    assign wr_go = AVS_WRITE_IN & ack_q;
    assign rd_go = AVS_READ_IN & ~ack_q;

    always @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ack_q <= 1'b0;
            AVS_WAITREQUEST_OUT <= 1'b1;
        end
        else
        begin
            // Drop waitrequest for exactly one edge, then rearm
            ack_q <= bus_req & ~ack_q;
            AVS_WAITREQUEST_OUT <= ~(bus_req & ~ack_q);
        end
    end

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    // Old contents come from the read mux, so byte enables merge cleanly
    always @*
    begin
        wr_word = merge(rdata_d, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
    end

    // Setpoint and limits share a percent scale; only the limits are compared, as is
    always @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ctrl_q <= `SOM_CTRL_RST;
            start_freq_threshold_q <= `SOM_START_FREQ_RST;
            pv_high_limit_q <= `SOM_PV_HIGH_RST;
            pv_low_limit_q <= `SOM_PV_LOW_RST;
            setpoint_q <= `SOM_SETPOINT_RST;
            irq_mask_q <= 4'h0;
        end
        else if (wr_go)
        begin
            case (AVS_ADDRESS_IN)
                `SOM_OFF_CTRL:
                    ctrl_q <= wr_word[3:0];
                `SOM_OFF_START_FREQ:
                    start_freq_threshold_q <= wr_word[W-1:0];
                `SOM_OFF_PV_HIGH:
                    pv_high_limit_q <= wr_word[W-1:0]; // see (R13)
                `SOM_OFF_PV_LOW:
                    pv_low_limit_q <= wr_word[W-1:0]; // see (R13)
                `SOM_OFF_SETPOINT:
                    setpoint_q <= wr_word[W-1:0]; // see (R13)
                `SOM_OFF_IRQ_MASK:
                    irq_mask_q <= wr_word[3:0];
                default:
                    irq_mask_q <= irq_mask_q;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Reference-loss detection
    // -----------------------------------------------------------------
    // Purely combinational from the inputs; nothing latches, so no clear
    always @*
    begin
        volt_loss = VOLT_REF_IN < start_freq_threshold_q; // see (R1)
        // Current source counts only below the 4 mA floor
        curr_loss = CURRENT_REF_INPUT_IN < `SOM_CURR_FLOOR_UA; // see (R2)
        // Microamps above the floor, for the monitor register
        if (curr_loss)
            curr_pct = {W{1'b0}}; // see (R3)
        else
            curr_pct = CURRENT_REF_INPUT_IN - `SOM_CURR_FLOOR_UA; // see (R3)
        // Voltage compare only used when that input is the source
        loss_d = (volt_loss & ctrl_q[`SOM_CTRL_SRC_BIT]) | curr_loss;
    end

    always @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            input_loss_flag_q <= 1'b0; // see (R15)
        else if (SAMPLE_IN)
            input_loss_flag_q <= loss_d; // see (R4) see (R5)
    end

    // -----------------------------------------------------------------
    // Second-stage hysteresis flag
    // -----------------------------------------------------------------
    som_hyst_flag #(.W(W)) u_stage
    (
        .clk(CLK_IN),
        .rst_n(RST_N_IN),
        .run(FORWARD_RUN_CMD_IN),
        .sample(SAMPLE_IN),
        .value(PROCESS_VALUE_IN),
        .low_lim(pv_low_limit_q),
        .high_lim(pv_high_limit_q),
        .flag_q(second_stage_flag)
    );

    // -----------------------------------------------------------------
    // Output terminals
    // -----------------------------------------------------------------
    // Registered so the helper drive sees a clean level
    always @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            INPUT_LOSS_FLAG_OUT <= 1'b0;
            SECOND_STAGE_FLAG_OUT <= 1'b0;
            TERMINAL_LOSS_OUT <= 1'b0;
            TERMINAL_STAGE_OUT <= 1'b0;
            DECEL_STOP_REQ_OUT <= 1'b0;
        end
        else
        begin
            INPUT_LOSS_FLAG_OUT <= input_loss_flag_q;
            SECOND_STAGE_FLAG_OUT <= second_stage_flag; // see (R14)
            TERMINAL_LOSS_OUT <= input_loss_flag_q &
                ctrl_q[`SOM_CTRL_LOSS_SEL_BIT]; // see (R7)
            TERMINAL_STAGE_OUT <= second_stage_flag &
                ctrl_q[`SOM_CTRL_STAGE_SEL_BIT];
            DECEL_STOP_REQ_OUT <= input_loss_flag_q &
                ctrl_q[`SOM_CTRL_DECEL_BIT]; // see (R6)
        end
    end

    // -----------------------------------------------------------------
    // Interrupts
    // -----------------------------------------------------------------
    // Edge events of both flags; a set in the clearing cycle wins
    assign events = {prev_stage_q & ~second_stage_flag,
                     ~prev_stage_q & second_stage_flag,
                     prev_loss_q & ~input_loss_flag_q,
                     ~prev_loss_q & input_loss_flag_q};

    always @*
    begin
        irq_stat_d = irq_stat_q;
        if (wr_go && AVS_ADDRESS_IN == `SOM_OFF_IRQ_STAT &&
            AVS_BYTEENABLE_IN[0])
            irq_stat_d = irq_stat_d & ~AVS_WRITEDATA_IN[3:0];
        irq_stat_d = irq_stat_d | events;
    end

    always @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            prev_loss_q <= 1'b0;
            prev_stage_q <= 1'b0;
            irq_stat_q <= 4'h0;
            IRQ_OUT <= 1'b0;
        end
        else
        begin
            prev_loss_q <= input_loss_flag_q;
            prev_stage_q <= second_stage_flag;
            irq_stat_q <= irq_stat_d;
            IRQ_OUT <= |(irq_stat_d & irq_mask_q);
        end
    end

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    // Unmapped offsets read as zero; data stands with waitrequest low
    always @*
    begin
        case (AVS_ADDRESS_IN)
            `SOM_OFF_CTRL: rdata_d = {28'h0000000, ctrl_q};
            `SOM_OFF_START_FREQ: rdata_d = widen(start_freq_threshold_q);
            `SOM_OFF_PV_HIGH: rdata_d = widen(pv_high_limit_q);
            `SOM_OFF_PV_LOW: rdata_d = widen(pv_low_limit_q);
            `SOM_OFF_SETPOINT: rdata_d = widen(setpoint_q);
            `SOM_OFF_STATUS:
                rdata_d = {30'h0, second_stage_flag,
                    input_loss_flag_q};
            `SOM_OFF_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
            `SOM_OFF_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
            `SOM_OFF_VOLT_MON: rdata_d = widen(VOLT_REF_IN);
            `SOM_OFF_CURR_MON: rdata_d = widen(curr_pct);
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            AVS_READDATA_OUT <= 32'h0000_0000;
        else if (rd_go)
            AVS_READDATA_OUT <= rdata_d;
    end

endmodule

// ==== test/som_props.sv ====
// Checker on the ports of the status output monitor top.
// Assumes binding onto som_top, one clock domain on CLK_IN.
`timescale 1ns/100ps
`include "som_consts.vh"

module som_props
#(
    parameter W = 16
)
(
    // Clock, reset and bus handshake
    input wire CLK_IN,
    input wire RST_N_IN,
    input wire AVS_READ_IN,
    input wire AVS_WRITE_IN,
    input wire AVS_WAITREQUEST_OUT,
    // Measurements
    input wire SAMPLE_IN,
    input wire FORWARD_RUN_CMD_IN,
    input wire [W-1:0] CURRENT_REF_INPUT_IN,
    // Status outputs
    input wire INPUT_LOSS_FLAG_OUT,
    input wire SECOND_STAGE_FLAG_OUT,
    input wire TERMINAL_LOSS_OUT,
    input wire TERMINAL_STAGE_OUT,
    input wire DECEL_STOP_REQ_OUT,
    input wire IRQ_OUT
);
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // Flag pins lag the strobe by two edges
    AST_CURR_LOSS: assert property (
        SAMPLE_IN && CURRENT_REF_INPUT_IN < `SOM_CURR_FLOOR_UA
        |-> ##2 INPUT_LOSS_FLAG_OUT)
        else $error("loss flag missed low current");
    AST_LOSS_ON_STROBE: assert property (
        $changed(INPUT_LOSS_FLAG_OUT) |-> $past(SAMPLE_IN, 2))
        else $error("loss flag moved without strobe");
    AST_STAGE_RISE: assert property (
        $rose(SECOND_STAGE_FLAG_OUT)
        |-> $past(SAMPLE_IN, 2) && $past(FORWARD_RUN_CMD_IN, 2))
        else $error("stage flag rose without run and strobe");
    AST_STAGE_STOP: assert property (
        !FORWARD_RUN_CMD_IN [*3] |-> !SECOND_STAGE_FLAG_OUT)
        else $error("stage flag held in stop mode");
    // Terminal copies may trail the flag by one edge on the way down
    AST_TERM_LOSS: assert property (
        TERMINAL_LOSS_OUT
        |-> INPUT_LOSS_FLAG_OUT || $past(INPUT_LOSS_FLAG_OUT))
        else $error("loss terminal without loss flag");
    AST_DECEL: assert property (
        DECEL_STOP_REQ_OUT
        |-> INPUT_LOSS_FLAG_OUT || $past(INPUT_LOSS_FLAG_OUT))
        else $error("stop request without loss flag");
    AST_TERM_STAGE: assert property (
        TERMINAL_STAGE_OUT
        |-> SECOND_STAGE_FLAG_OUT || $past(SECOND_STAGE_FLAG_OUT))
        else $error("helper command without stage flag");
    AST_RESET_CLEAR: assert property (
        $rose(RST_N_IN) |-> !INPUT_LOSS_FLAG_OUT && !IRQ_OUT
        && !SECOND_STAGE_FLAG_OUT && AVS_WAITREQUEST_OUT)
        else $error("outputs not cleared by reset");
    AST_WAIT_ANSWER: assert property (
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
        |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
        else $error("bus answer not one cycle after request");
endmodule

bind som_top som_props #(.W(W)) som_props_inst (.CLK_IN, .RST_N_IN,
    .AVS_READ_IN, .AVS_WRITE_IN, .AVS_WAITREQUEST_OUT, .SAMPLE_IN,
    .FORWARD_RUN_CMD_IN, .CURRENT_REF_INPUT_IN, .INPUT_LOSS_FLAG_OUT,
    .SECOND_STAGE_FLAG_OUT, .TERMINAL_LOSS_OUT, .TERMINAL_STAGE_OUT,
    .DECEL_STOP_REQ_OUT, .IRQ_OUT);

// ==== test/som_stage2_model.sv ====
// Helper drive model: runs forward while its command is high.
// Assumes the command is synchronous to the bench clock.
`timescale 1ns/100ps

module som_stage2_model
#(
    parameter LAG = 0
)
(
    // Clock and reset
    input wire clk_in,
    input wire rst_n_in,
    // Command and state
    input wire run_fwd_in,
    output reg running_out
);
    reg [3:0] cnt_q;

    // Follow the command LAG+1 cycles after it changes, as a slow drive would
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cnt_q <= 4'h0;
            running_out <= 1'b0;
        end
        else if (run_fwd_in == running_out)
            cnt_q <= 4'h0;
        else if (cnt_q >= LAG)
        begin
            running_out <= run_fwd_in;
            cnt_q <= 4'h0;
        end
        else
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

// ==== test/status_output_monitor_bench.sv ====
// Self-checking bench for the status output monitor.
// Assumes design, checker and helper model are compiled first.
`timescale 1ns/100ps
`include "som_consts.vh"

module status_output_monitor_bench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] adr = 8'h00;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg [31:0] wdat = 32'h0;
    reg smp = 1'b0;
    reg run = 1'b0;
    reg [15:0] volt = 16'h0;
    reg [15:0] curr = 16'h1000;
    reg [15:0] pv = 16'h0;
    wire [31:0] rdat;
    wire wait_o, loss, stage, t_loss, t_stage, decel, irq, helper;
    // Bench model of the registers and flags
    reg [15:0] thr = 16'h0;
    reg [15:0] hi = 16'h0;
    reg [15:0] lo = 16'h0;
    reg [3:0] ctrl = 4'hf;
    reg [3:0] mask = 4'h0;
    reg [3:0] ev = 4'h0;
    reg e_loss = 1'b0;
    reg e_stage = 1'b0;
    reg [38:0] notes[$];
    integer fail_count = 0;
    integer n_tests = 0;
    integer seed;

    always #5 clk = ~clk;

    som_top #(.W(16)) som_top_inst (.CLK_IN(clk), .RST_N_IN(rst_n),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hf),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wait_o),
        .SAMPLE_IN(smp), .FORWARD_RUN_CMD_IN(run), .VOLT_REF_IN(volt),
        .CURRENT_REF_INPUT_IN(curr), .PROCESS_VALUE_IN(pv),
        .INPUT_LOSS_FLAG_OUT(loss), .SECOND_STAGE_FLAG_OUT(stage),
        .TERMINAL_LOSS_OUT(t_loss), .TERMINAL_STAGE_OUT(t_stage),
        .DECEL_STOP_REQ_OUT(decel), .IRQ_OUT(irq));

    // Slow helper drive, so its start lags the command
    som_stage2_model #(.LAG(3)) som_stage2_model_inst (.clk_in(clk),
        .rst_n_in(rst_n), .run_fwd_in(t_stage), .running_out(helper));

    // Each completed read, with the pins, against the oldest note
    always @(posedge clk)
    begin
        if (rd && !wait_o)
        begin
            n_tests = n_tests + 1;
            if ({helper, decel, t_stage, t_loss, irq, stage, loss, rdat}
                !== notes.pop_front())
            begin
                fail_count = fail_count + 1;
                $display("MISMATCH at %0t: addr %h read %h", $time, adr, rdat);
            end
        end
    end

    task print_verdict;
        begin
            if (fail_count == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // One bus cycle; waits for the answer, never a fixed count
    task bus(input w, input [7:0] a, input [31:0] d);
        integer i;
        begin
            i = 0;
            @(posedge clk);
            adr <= a;
            wdat <= d;
            rd <= !w;
            wr <= w;
            @(posedge clk);
            while (wait_o && i < 20)
            begin
                @(posedge clk);
                i = i + 1;
            end
            rd <= 1'b0;
            wr <= 1'b0;
            if (wait_o)
            begin
                fail_count = fail_count + 1;
                $display("MISMATCH at %0t: bus answer timed out", $time);
                print_verdict;
            end
        end
    endtask

    task chk(input [7:0] a, input [31:0] d);
        begin
            notes.push_back({e_stage & ctrl[3], e_loss & ctrl[1],
                e_stage & ctrl[3], e_loss & ctrl[2], |(ev & mask),
                e_stage, e_loss, d});
            bus(1'b0, a, 32'h0);
        end
    endtask

    // Apply inputs, strobe once if asked, then check the status word
    task step(input [15:0] v, c, p, input r, s);
        reg nl, ns;
        begin
            @(posedge clk);
            volt <= v;
            curr <= c;
            pv <= p;
            run <= r;
            smp <= s;
            @(posedge clk);
            smp <= 1'b0;
            repeat (8) @(posedge clk);
            nl = s ? (v < thr && ctrl[0]) || c < `SOM_CURR_FLOOR_UA : e_loss;
            ns = !r ? 1'b0 : !s ? e_stage : p < lo ? 1'b1
                : p > hi ? 1'b0 : e_stage;
            ev = ev | {e_stage & !ns, !e_stage & ns, e_loss & !nl,
                !e_loss & nl};
            e_loss = nl;
            e_stage = ns;
            chk(`SOM_OFF_STATUS, {30'h0, ns, nl});
        end
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        seed = $urandom(29);
        chk(`SOM_OFF_CTRL, 32'hf);
        chk(`SOM_OFF_START_FREQ, 32'h0);
        chk(`SOM_OFF_IRQ_MASK, 32'h0);
        chk(8'h3c, 32'h0);
        bus(1'b1, `SOM_OFF_START_FREQ, 32'h200);
        bus(1'b1, `SOM_OFF_PV_HIGH, 32'h50);
        bus(1'b1, `SOM_OFF_PV_LOW, 32'h20);
        bus(1'b1, `SOM_OFF_IRQ_MASK, 32'h1);
        bus(1'b1, `SOM_OFF_SETPOINT, 32'h40);
        chk(`SOM_OFF_SETPOINT, 32'h40);
        thr = 16'h200;
        hi = 16'h50;
        lo = 16'h20;
        mask = 4'h1;
        step(16'h1ff, 16'h1000, 16'h10, 1'b1, 1'b1);
        chk(`SOM_OFF_CURR_MON, 32'h1000 - `SOM_CURR_FLOOR_UA);
        step(16'h200, 16'h1000, 16'h30, 1'b1, 1'b1);
        step(16'h300, 16'h0f9f, 16'h51, 1'b1, 1'b1);
        step(16'h300, 16'h0fa0, 16'h30, 1'b1, 1'b1);
        chk(`SOM_OFF_CURR_MON, 32'h0);
        step(16'h300, 16'h1000, 16'h1f, 1'b1, 1'b1);
        step(16'h0, 16'h1000, 16'h10, 1'b0, 1'b0);
        repeat (8)
            step(16'($urandom_range(16'h280, 16'h180)),
                16'($urandom_range(16'h1000, 16'h0f00)),
                16'($urandom_range(16'h60, 16'h0)), 1'b1, 1'b1);
        chk(`SOM_OFF_IRQ_STAT, {28'h0, ev});
        bus(1'b1, `SOM_OFF_IRQ_STAT, 32'hf);
        ev = 4'h0;
        chk(`SOM_OFF_IRQ_STAT, 32'h0);
        bus(1'b1, `SOM_OFF_CTRL, 32'h0);
        ctrl = 4'h0;
        step(16'h0, 16'h1000, 16'h10, 1'b1, 1'b1);
        step(16'h0, 16'h0100, 16'h30, 1'b1, 1'b1);
        // Mid-run reset with both flags set; no strobe follows, so they
        // must stay clear although the low current input persists
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        ctrl = 4'hf;
        mask = 4'h0;
        ev = 4'h0;
        e_loss = 1'b0;
        e_stage = 1'b0;
        chk(`SOM_OFF_STATUS, 32'h0);
        chk(`SOM_OFF_CTRL, 32'hf);
        print_verdict;
    end
endmodule
